// >>> rtl/citf_pkg.sv
// Constants, opcodes, flag layout and shared types of the instruction tail decoder.
//------------------------------------------------------------------------------
// Functional notes
// - After every ALU, bit, rotate or shift operation the flags show its outcome.
// - Flags hold six status bits: carry, zero, sign, overflow, decimal, half-carry.
// - Conditional jumps can test carry, overflow, zero and sign.
// - Half-carry and decimal flags are never jump conditions; they serve BCD only.
// - User flags change only through explicit writes and interrupt return, never through arithmetic.
// - User flags are never offered as jump conditions.
// - User flags have no reset value and keep their content through reset.
// - Interrupt and software trap entry push the flags onto the stack; an illegal opcode only pulses illegal_o.
// - Interrupt return reloads the flags from the value saved on the stack.
// - Arithmetic right shift keeps bit 7, bit 0 to carry, clears overflow.
// - Logical right shift uses prefixed opcodes, fills bit 7 with zero, clears sign.
// - Trap drops stack by two, stores PC, drops one, stores flags, loads vector.
// - Exclusive-or writes back, clears overflow, derives zero and sign from the result, keeps carry.
// - Each instruction derives, keeps, leaves undefined, clears or sets each flag.
//------------------------------------------------------------------------------
package citf_pkg;
    // Flag byte layout; the six status bits sit in the upper positions.
    localparam int FLAG_C_BIT = 7;
    localparam int FLAG_Z_BIT = 6;
    localparam int FLAG_S_BIT = 5;
    localparam int FLAG_V_BIT = 4;
    localparam int FLAG_D_BIT = 3;
    localparam int FLAG_H_BIT = 2;
    localparam int FLAG_U2_BIT = 1;
    localparam int FLAG_U1_BIT = 0;
    localparam int STATUS_W = 6;
    localparam int USER_W = 2;
    localparam logic [STATUS_W-1:0] STATUS_RST = 6'h00;
    localparam logic [7:0] GPTR_RST = 8'h00;

    localparam logic [7:0] OPC_PREFIX = 8'h1F;
    localparam logic [7:0] OPC_CSET = 8'hDF;
    localparam logic [7:0] OPC_ASR_R = 8'hD0;
    localparam logic [7:0] OPC_ASR_IR = 8'hD1;
    localparam logic [7:0] OPC_LSR_R = 8'hC0;
    localparam logic [7:0] OPC_LSR_IR = 8'hC1;
    localparam logic [7:0] OPC_GPTR = 8'h01;
    localparam logic [7:0] OPC_STOP = 8'h6F;
    localparam logic [7:0] OPC_SWAP_R = 8'hF0;
    localparam logic [7:0] OPC_SWAP_IR = 8'hF1;
    localparam logic [7:0] OPC_TRAP = 8'hF2;
    localparam logic [7:0] OPC_WDT = 8'h5F;
    localparam logic [3:0] GRP_SUB = 4'h2;
    localparam logic [3:0] GRP_CMSK = 4'h6;
    localparam logic [3:0] GRP_MSK = 4'h7;
    localparam logic [3:0] GRP_XOR = 4'hB;
    localparam logic [3:0] ALU_LO_FIRST = 4'h2;
    localparam logic [3:0] ALU_LO_LAST = 4'h9;

    // Execute cycle counts.
    localparam logic [3:0] CYC_SIMPLE = 4'h2;
    localparam logic [3:0] CYC_SHIFT_IND = 4'h3;
    localparam logic [3:0] CYC_ALU_DIR = 4'h3;
    localparam logic [3:0] CYC_ALU_IND = 4'h4;
    localparam logic [3:0] CYC_TRAP = 4'h6;
    localparam logic [3:0] CYC_TRAP_PC = 4'h6;
    localparam logic [3:0] CYC_TRAP_FLAGS = 4'h5;

    typedef enum logic [3:0] {
        CL_ILLEGAL, CL_CSET, CL_ASR, CL_LSR, CL_GPTR, CL_STOP, CL_SUB,
        CL_SWAP, CL_CMSK, CL_MSK, CL_TRAP, CL_WDT, CL_XOR
    } citf_class_type;

    typedef enum logic [2:0] {
        FA_KEEP, FA_RESULT, FA_UNDEF, FA_ZERO, FA_ONE
    } citf_flag_act_type;
endpackage : citf_pkg

// >>> rtl/citf_flag_if.sv
// Carrier between the decoder core and its flags register.
`timescale 1ns/1ps
interface citf_flag_if;
    logic upd_valid;
    logic [citf_pkg::STATUS_W-1:0] upd_mask;
    logic [citf_pkg::STATUS_W-1:0] upd_val;
    logic restore_valid;
    logic [7:0] restore_data;
    logic user_we;
    logic [citf_pkg::USER_W-1:0] user_data;
    logic [7:0] flags;

    modport core (
        output upd_valid, upd_mask, upd_val, restore_valid, restore_data,
        output user_we, user_data,
        input flags
    );
    modport store (
        input upd_valid, upd_mask, upd_val, restore_valid, restore_data,
        input user_we, user_data,
        output flags
    );
endinterface : citf_flag_if

// >>> rtl/citf_flag_reg.sv
// Flags register: six resettable status bits and two unreset user bits.
`timescale 1ns/1ps
module citf_flag_reg (
    input wire logic clk_i,
    input wire logic rst_b_i,
    citf_flag_if.store fi
);
    typedef struct packed {
        logic [citf_pkg::STATUS_W-1:0] status;
    } citf_flag_state_type;

    citf_flag_state_type s_r;
    citf_flag_state_type s_nxt;
    logic [citf_pkg::USER_W-1:0] user_r;
    logic [citf_pkg::USER_W-1:0] user_nxt;

    //--------------------------------------------------------------------------
    // Update priority: restore from stack, then explicit user write, then ALU.
    //--------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        user_nxt = user_r;
        if (fi.restore_valid) begin
            s_nxt.status = fi.restore_data[citf_pkg::FLAG_C_BIT:citf_pkg::FLAG_H_BIT];
            user_nxt = fi.restore_data[citf_pkg::FLAG_U2_BIT:citf_pkg::FLAG_U1_BIT];
        end else begin
            if (fi.user_we) begin
                user_nxt = fi.user_data;
            end
            if (fi.upd_valid) begin
                s_nxt.status = (s_r.status & ~fi.upd_mask) | (fi.upd_val & fi.upd_mask);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r.status <= citf_pkg::STATUS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Deliberately outside the reset so software status survives a reset.
    always_ff @(posedge clk_i) begin
        user_r <= user_nxt;
    end

    assign fi.flags = {s_r.status, user_r};
endmodule : citf_flag_reg

// >>> rtl/citf_core.sv
// Decoder and sequencer for the instruction tail and the flags register.
`timescale 1ns/1ps
module citf_core #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic issue_valid_i,
    output logic issue_ready_o,
    input wire logic prefix_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] dst_i,
    input wire logic [7:0] src_i,
    input wire logic [ADDR_W-1:0] pc_i,
    input wire logic [ADDR_W-1:0] sp_i,
    input wire logic [ADDR_W-1:0] vector_i,
    input wire logic irq_entry_i,
    input wire logic irq_exit_i,
    input wire logic [7:0] stack_flags_i,
    input wire logic uflag_we_i,
    input wire logic [1:0] uflag_i,
    input wire logic [3:0] cond_i,
    output logic cond_true_o,
    output logic [7:0] flags_o,
    output logic done_o,
    output logic result_we_o,
    output logic [7:0] result_o,
    output logic mem_we_o,
    output logic mem_word_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [ADDR_W-1:0] mem_wdata_o,
    output logic sp_we_o,
    output logic [ADDR_W-1:0] sp_o,
    output logic pc_we_o,
    output logic [ADDR_W-1:0] pc_o,
    output logic [7:0] working_group_pointer_o,
    output logic stop_req_o,
    output logic wdt_refresh_o,
    output logic illegal_o
);
    // Stack and vector arithmetic is sized for 12 to 32 bit addresses.
    // Anything outside that span is refused when the design is elaborated.
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_w_check
        $error("ADDR_W out of range");
    end

    typedef enum logic {ST_IDLE, ST_EXEC} citf_state_type;

    typedef struct packed {
        citf_pkg::citf_class_type cls;
        logic [3:0] cyc;
        logic [7:0] res;
        logic wb;
        logic [citf_pkg::STATUS_W-1:0] mask;
        logic [citf_pkg::STATUS_W-1:0] val;
    } citf_alu_type;

    typedef struct packed {
        citf_state_type st;
        logic [3:0] cnt;
        citf_pkg::citf_class_type cls;
        logic [7:0] res;
        logic wb;
        logic [citf_pkg::STATUS_W-1:0] mask;
        logic [citf_pkg::STATUS_W-1:0] val;
        logic [ADDR_W-1:0] sp;
        logic [ADDR_W-1:0] pc_save;
        logic [ADDR_W-1:0] vec;
        logic upd;
        logic done;
        logic res_we;
        logic [7:0] res_out;
        logic mem_we;
        logic mem_word;
        logic [ADDR_W-1:0] mem_addr;
        logic [ADDR_W-1:0] mem_wdata;
        logic sp_we;
        logic [ADDR_W-1:0] sp_out;
        logic pc_we;
        logic [ADDR_W-1:0] pc_out;
        logic [7:0] gptr;
        logic stop;
        logic wdt;
        logic illegal;
    } citf_core_state_type;

    citf_core_state_type s_r;
    citf_core_state_type s_nxt;
    citf_alu_type alu;
    logic take_entry;
    logic take_exit;
    logic take_issue;

    citf_flag_if fi ();

    citf_flag_reg u_flags (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .fi(fi)
    );

    //--------------------------------------------------------------------------
    // Flag action helpers.
    //--------------------------------------------------------------------------
    function automatic logic act_mask(input citf_pkg::citf_flag_act_type a);
        // Undefined flags are left holding their old value.
        act_mask = (a == citf_pkg::FA_RESULT) || (a == citf_pkg::FA_ZERO)
                   || (a == citf_pkg::FA_ONE);
    endfunction : act_mask

    function automatic logic act_val(input citf_pkg::citf_flag_act_type a, input logic d);
        act_val = (a == citf_pkg::FA_ONE) ? 1'b1 : ((a == citf_pkg::FA_ZERO) ? 1'b0 : d);
    endfunction : act_val

    function automatic logic alu_low_ok(input logic [3:0] lo);
        alu_low_ok = (lo >= citf_pkg::ALU_LO_FIRST) && (lo <= citf_pkg::ALU_LO_LAST);
    endfunction : alu_low_ok

    // Indirect forms of the two-operand group take one more cycle.
    function automatic logic [3:0] alu_cycles(input logic [3:0] lo);
        if (lo == 4'h3 || lo == 4'h5 || lo == 4'h7) begin
            alu_cycles = citf_pkg::CYC_ALU_IND;
        end else begin
            alu_cycles = citf_pkg::CYC_ALU_DIR;
        end
    endfunction : alu_cycles

    //--------------------------------------------------------------------------
    // Decode and compute. Operands arrive already fetched by the addressing unit.
    //--------------------------------------------------------------------------
    function automatic citf_alu_type execute(
        input logic pfx,
        input logic [7:0] op,
        input logic [7:0] d,
        input logic [7:0] s
    );
        citf_alu_type r;
        citf_pkg::citf_flag_act_type ac, az, as, av, ad, ah;
        logic fc, fv, fh;
        logic [8:0] diff;
        r.cls = citf_pkg::CL_ILLEGAL;
        r.cyc = citf_pkg::CYC_SIMPLE;
        r.res = d;
        r.wb = 1'b0;
        ac = citf_pkg::FA_KEEP;
        az = citf_pkg::FA_KEEP;
        as = citf_pkg::FA_KEEP;
        av = citf_pkg::FA_KEEP;
        ad = citf_pkg::FA_KEEP;
        ah = citf_pkg::FA_KEEP;
        fc = 1'b0;
        fv = 1'b0;
        fh = 1'b0;
        diff = {1'b0, d} - {1'b0, s};
        if (pfx) begin
            if (op == citf_pkg::OPC_LSR_R || op == citf_pkg::OPC_LSR_IR) begin
                r.cls = citf_pkg::CL_LSR;
                r.cyc = (op[0]) ? citf_pkg::CYC_SHIFT_IND : citf_pkg::CYC_SIMPLE;
                r.res = {1'b0, d[7:1]};
                r.wb = 1'b1;
                fc = d[0];
                fv = d[7];
                ac = citf_pkg::FA_RESULT;
                az = citf_pkg::FA_RESULT;
                as = citf_pkg::FA_ZERO;
                av = citf_pkg::FA_RESULT;
            end
        end else if (op == citf_pkg::OPC_CSET) begin
            r.cls = citf_pkg::CL_CSET;
            ac = citf_pkg::FA_ONE;
        end else if (op == citf_pkg::OPC_ASR_R || op == citf_pkg::OPC_ASR_IR) begin
            r.cls = citf_pkg::CL_ASR;
            r.cyc = (op[0]) ? citf_pkg::CYC_SHIFT_IND : citf_pkg::CYC_SIMPLE;
            r.res = {d[7], d[7:1]};
            r.wb = 1'b1;
            fc = d[0];
            ac = citf_pkg::FA_RESULT;
            az = citf_pkg::FA_RESULT;
            as = citf_pkg::FA_RESULT;
            av = citf_pkg::FA_ZERO;
        end else if (op == citf_pkg::OPC_GPTR) begin
            r.cls = citf_pkg::CL_GPTR;
            r.res = s;
        end else if (op == citf_pkg::OPC_STOP) begin
            r.cls = citf_pkg::CL_STOP;
        end else if (op == citf_pkg::OPC_WDT) begin
            r.cls = citf_pkg::CL_WDT;
        end else if (op == citf_pkg::OPC_TRAP) begin
            r.cls = citf_pkg::CL_TRAP;
            r.cyc = citf_pkg::CYC_TRAP;
        end else if (op == citf_pkg::OPC_SWAP_R || op == citf_pkg::OPC_SWAP_IR) begin
            r.cls = citf_pkg::CL_SWAP;
            r.cyc = (op[0]) ? citf_pkg::CYC_SHIFT_IND : citf_pkg::CYC_SIMPLE;
            r.res = {d[3:0], d[7:4]};
            r.wb = 1'b1;
            ac = citf_pkg::FA_UNDEF;
            az = citf_pkg::FA_RESULT;
            as = citf_pkg::FA_RESULT;
            av = citf_pkg::FA_UNDEF;
        end else if (alu_low_ok(op[3:0])) begin
            r.cyc = alu_cycles(op[3:0]);
            az = citf_pkg::FA_RESULT;
            as = citf_pkg::FA_RESULT;
            av = citf_pkg::FA_ZERO;
            case (op[7:4])
                citf_pkg::GRP_SUB: begin
                    r.cls = citf_pkg::CL_SUB;
                    r.res = diff[7:0];
                    r.wb = 1'b1;
                    fc = diff[8];
                    fv = (d[7] ^ s[7]) & (diff[7] ^ d[7]);
                    fh = d[3:0] < s[3:0];
                    ac = citf_pkg::FA_RESULT;
                    av = citf_pkg::FA_RESULT;
                    ad = citf_pkg::FA_ONE;
                    ah = citf_pkg::FA_RESULT;
                end
                citf_pkg::GRP_CMSK: begin
                    r.cls = citf_pkg::CL_CMSK;
                    r.res = ~d & s;
                end
                citf_pkg::GRP_MSK: begin
                    r.cls = citf_pkg::CL_MSK;
                    r.res = d & s;
                end
                citf_pkg::GRP_XOR: begin
                    r.cls = citf_pkg::CL_XOR;
                    r.res = d ^ s;
                    r.wb = 1'b1;
                end
                default: begin
                    az = citf_pkg::FA_KEEP;
                    as = citf_pkg::FA_KEEP;
                    av = citf_pkg::FA_KEEP;
                end
            endcase
        end
        r.mask = {act_mask(ac), act_mask(az), act_mask(as),
                  act_mask(av), act_mask(ad), act_mask(ah)};
        r.val = {act_val(ac, fc), act_val(az, r.res == 8'h00), act_val(as, r.res[7]),
                 act_val(av, fv), act_val(ad, 1'b0), act_val(ah, fh)};
        execute = r;
    endfunction : execute

    //--------------------------------------------------------------------------
    // Jump conditions look only at carry, zero, sign and overflow.
    //--------------------------------------------------------------------------
    function automatic logic cond_eval(input logic [3:0] cc, input logic [7:0] f);
        logic c, z, sg, v;
        c = f[citf_pkg::FLAG_C_BIT];
        z = f[citf_pkg::FLAG_Z_BIT];
        sg = f[citf_pkg::FLAG_S_BIT];
        v = f[citf_pkg::FLAG_V_BIT];
        case (cc)
            4'h0: cond_eval = 1'b0;
            4'h1: cond_eval = sg ^ v;
            4'h2: cond_eval = z | (sg ^ v);
            4'h3: cond_eval = c | z;
            4'h4: cond_eval = v;
            4'h5: cond_eval = sg;
            4'h6: cond_eval = z;
            4'h7: cond_eval = c;
            4'h8: cond_eval = 1'b1;
            4'h9: cond_eval = ~(sg ^ v);
            4'hA: cond_eval = ~(z | (sg ^ v));
            4'hB: cond_eval = ~(c | z);
            4'hC: cond_eval = ~v;
            4'hD: cond_eval = ~sg;
            4'hE: cond_eval = ~z;
            default: cond_eval = ~c;
        endcase
    endfunction : cond_eval

    //--------------------------------------------------------------------------
    // Sequencer.
    //--------------------------------------------------------------------------
    assign alu = execute(prefix_i, opcode_i, dst_i, src_i);
    assign take_entry = (s_r.st == ST_IDLE) && irq_entry_i;
    assign take_exit = (s_r.st == ST_IDLE) && !irq_entry_i && irq_exit_i;
    assign take_issue = (s_r.st == ST_IDLE) && !irq_entry_i && !irq_exit_i && issue_valid_i;

    always_comb begin
        s_nxt = s_r;
        s_nxt.upd = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.res_we = 1'b0;
        s_nxt.mem_we = 1'b0;
        s_nxt.sp_we = 1'b0;
        s_nxt.pc_we = 1'b0;
        s_nxt.stop = 1'b0;
        s_nxt.wdt = 1'b0;
        s_nxt.illegal = 1'b0;
        case (s_r.st)
            ST_IDLE: begin
                if (take_entry) begin
                    s_nxt.st = ST_EXEC;
                    s_nxt.cls = citf_pkg::CL_TRAP;
                    s_nxt.cnt = citf_pkg::CYC_TRAP;
                    s_nxt.wb = 1'b0;
                    s_nxt.mask = '0;
                    s_nxt.sp = sp_i;
                    s_nxt.pc_save = pc_i;
                    s_nxt.vec = vector_i;
                end else if (take_issue) begin
                    if (alu.cls == citf_pkg::CL_ILLEGAL) begin
                        s_nxt.illegal = 1'b1;
                    end else begin
                        s_nxt.st = ST_EXEC;
                        s_nxt.cls = alu.cls;
                        s_nxt.cnt = alu.cyc;
                        s_nxt.res = alu.res;
                        s_nxt.wb = alu.wb;
                        s_nxt.mask = alu.mask;
                        s_nxt.val = alu.val;
                        s_nxt.sp = sp_i;
                        s_nxt.pc_save = pc_i;
                        s_nxt.vec = vector_i;
                    end
                end
            end
            ST_EXEC: begin
                s_nxt.cnt = s_r.cnt - 4'h1;
                if (s_r.cls == citf_pkg::CL_TRAP) begin
                    if (s_r.cnt == citf_pkg::CYC_TRAP_PC) begin
                        s_nxt.sp = s_r.sp - ADDR_W'(2);
                        s_nxt.mem_we = 1'b1;
                        s_nxt.mem_word = 1'b1;
                        s_nxt.mem_addr = s_r.sp - ADDR_W'(2);
                        s_nxt.mem_wdata = s_r.pc_save;
                    end else if (s_r.cnt == citf_pkg::CYC_TRAP_FLAGS) begin
                        s_nxt.sp = s_r.sp - ADDR_W'(1);
                        s_nxt.mem_we = 1'b1;
                        s_nxt.mem_word = 1'b0;
                        s_nxt.mem_addr = s_r.sp - ADDR_W'(1);
                        s_nxt.mem_wdata = ADDR_W'(fi.flags);
                        s_nxt.sp_we = 1'b1;
                        s_nxt.sp_out = s_r.sp - ADDR_W'(1);
                    end
                end
                if (s_r.cnt == 4'h1) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.done = 1'b1;
                    s_nxt.upd = |s_r.mask;
                    s_nxt.res_we = s_r.wb;
                    s_nxt.res_out = s_r.res;
                    s_nxt.stop = (s_r.cls == citf_pkg::CL_STOP);
                    s_nxt.wdt = (s_r.cls == citf_pkg::CL_WDT);
                    if (s_r.cls == citf_pkg::CL_GPTR) begin
                        s_nxt.gptr = s_r.res;
                    end
                    if (s_r.cls == citf_pkg::CL_TRAP) begin
                        s_nxt.pc_we = 1'b1;
                        s_nxt.pc_out = s_r.vec;
                    end
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.cls <= citf_pkg::CL_ILLEGAL;
            s_r.gptr <= citf_pkg::GPTR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // Flags register hookup and outputs.
    //--------------------------------------------------------------------------
    assign fi.upd_valid = s_r.upd;
    assign fi.upd_mask = s_r.mask;
    assign fi.upd_val = s_r.val;
    assign fi.restore_valid = take_exit;
    assign fi.restore_data = stack_flags_i;
    assign fi.user_we = uflag_we_i;
    assign fi.user_data = uflag_i;

    assign issue_ready_o = (s_r.st == ST_IDLE) && !irq_entry_i && !irq_exit_i;
    assign cond_true_o = cond_eval(cond_i, fi.flags);
    assign flags_o = fi.flags;
    assign done_o = s_r.done;
    assign result_we_o = s_r.res_we;
    assign result_o = s_r.res_out;
    assign mem_we_o = s_r.mem_we;
    assign mem_word_o = s_r.mem_word;
    assign mem_addr_o = s_r.mem_addr;
    assign mem_wdata_o = s_r.mem_wdata;
    assign sp_we_o = s_r.sp_we;
    assign sp_o = s_r.sp_out;
    assign pc_we_o = s_r.pc_we;
    assign pc_o = s_r.pc_out;
    assign working_group_pointer_o = s_r.gptr;
    assign stop_req_o = s_r.stop;
    assign wdt_refresh_o = s_r.wdt;
    assign illegal_o = s_r.illegal;
endmodule : citf_core

// >>> dv/citf_core_asserts.sv
// Port-level checks of the instruction tail decoder.
`timescale 1ns/1ps
module citf_core_asserts (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic issue_valid_i,
    input wire logic issue_ready_o,
    input wire logic prefix_i,
    input wire logic [7:0] opcode_i,
    input wire logic irq_entry_i,
    input wire logic irq_exit_i,
    input wire logic [7:0] stack_flags_i,
    input wire logic uflag_we_i,
    input wire logic [3:0] cond_i,
    input wire logic cond_true_o,
    input wire logic [7:0] flags_o,
    input wire logic done_o,
    input wire logic result_we_o,
    input wire logic mem_we_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire take = issue_valid_i && issue_ready_o && !prefix_i;
    wire trap = take && opcode_i == citf_pkg::OPC_TRAP;
    // User bits power up unknown, so their stability is judged only after a write.
    logic wr_seen_r = 1'b0;
    always_ff @(posedge clk_i) if (uflag_we_i) wr_seen_r <= 1'b1;
    a_trap_push_twice: assert property (trap |-> ##2 mem_we_o ##1 mem_we_o)
        else $error("trap push missing");
    a_trap_six_cycles: assert property (trap |-> ##7 done_o)
        else $error("trap length wrong");
    a_exit_restore: assert property (irq_exit_i && !irq_entry_i &&
        $past(issue_ready_o && !issue_valid_i) |=> flags_o == $past(stack_flags_i))
        else $error("flags not restored");
    a_user_bits_kept: assert property ($past(wr_seen_r && !uflag_we_i && !irq_exit_i)
        |-> $stable(flags_o[1:0])) else $error("user flags changed");
    a_cond_flag_map: assert property (cond_i[2] |->
        cond_true_o == (flags_o[{1'b1, cond_i[1:0]}] ^ cond_i[3])) else $error("cond wrong");
    a_sra_clears_v: assert property (take && opcode_i == 8'hD0
        |-> ##3 done_o ##1 !flags_o[4]) else $error("shift flags wrong");
    a_xor_writes_back: assert property (take && opcode_i == 8'hB4
        |-> ##4 done_o && result_we_o) else $error("xor write missing");
    a_test_no_write: assert property (take && opcode_i inside {8'h62, 8'h72}
        |-> ##4 done_o && !result_we_o) else $error("test wrote back");
endmodule : citf_core_asserts
bind citf_core citf_core_asserts u_citf_core_asserts (.*);

// >>> dv/citf_core_test.sv
// Directed bench for the instruction tail decoder.
`timescale 1ns/1ps
module citf_core_test;
    logic clk_i = 1'b0, rst_b_i = 1'b0, issue_valid_i = 1'b0, prefix_i = 1'b0;
    logic irq_entry_i = 1'b0, irq_exit_i = 1'b0, uflag_we_i = 1'b0;
    logic [1:0] uflag_i = 2'h0;
    logic [3:0] cond_i = 4'h0;
    logic [7:0] opcode_i = 8'h00, dst_i = 8'h00, src_i = 8'h00, stack_flags_i = 8'h00;
    logic [15:0] pc_i = 16'h1234, sp_i = 16'h0100, vector_i = 16'h4000;
    logic issue_ready_o, cond_true_o, done_o, result_we_o, mem_we_o, mem_word_o;
    logic sp_we_o, pc_we_o, stop_req_o, wdt_refresh_o, illegal_o;
    logic [7:0] flags_o, result_o, working_group_pointer_o;
    logic [15:0] mem_addr_o, mem_wdata_o, sp_o, pc_o;
    int failures = 0, n_tests = 0;
    citf_core u_citf_core (.*);
    task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    // Offers one instruction, then judges its done cycle and the flags one edge later.
    task automatic iss(input logic p, input logic [7:0] op, d, s, input int n,
            input logic we, input logic [7:0] res, input logic [5:0] fl);
        @(negedge clk_i);
        {prefix_i, opcode_i, dst_i, src_i, issue_valid_i} = {p, op, d, s, 1'b1};
        @(negedge clk_i);
        issue_valid_i = 1'b0;
        chk("busy", issue_ready_o, 1'b0);
        repeat (n) @(negedge clk_i);
        chk("done", {done_o, result_we_o}, {1'b1, we});
        chk("events", {stop_req_o, wdt_refresh_o},
            {!p && op == citf_pkg::OPC_STOP, !p && op == citf_pkg::OPC_WDT});
        if (we) chk("result", result_o, res);
        @(negedge clk_i);
        chk("flags", flags_o[7:2], fl);
    endtask : iss
    task automatic trap(input logic irq, input logic [7:0] f);
        @(negedge clk_i);
        if (irq) irq_entry_i = 1'b1;
        else {opcode_i, issue_valid_i} = {citf_pkg::OPC_TRAP, 1'b1};
        @(negedge clk_i);
        {irq_entry_i, issue_valid_i} = 2'b00;
        @(negedge clk_i);
        chk("pc push", {mem_we_o, mem_word_o, mem_addr_o}, {2'b11, sp_i - 16'h2});
        chk("pc data", mem_wdata_o, pc_i);
        @(negedge clk_i);
        chk("flag push", {mem_we_o, mem_word_o, mem_addr_o}, {2'b10, sp_i - 16'h3});
        chk("flag data", {mem_wdata_o[7:0], sp_we_o, sp_o}, {f, 1'b1, sp_i - 16'h3});
        repeat (4) @(negedge clk_i);
        chk("vector", {done_o, pc_we_o, pc_o}, {2'b11, vector_i});
        chk("trap flags", flags_o, f);
    endtask : trap
    task automatic t_user;
        @(negedge clk_i);
        {uflag_we_i, uflag_i} = 3'b110;
        @(negedge clk_i);
        {uflag_we_i, rst_b_i} = 2'b00;
        @(negedge clk_i);
        rst_b_i = 1'b1;
        chk("user", flags_o, 8'h02);
    endtask : t_user
    task automatic t_alu;
        iss(0, 8'hDF, 8'h00, 8'h00, 2, 0, 8'h00, 6'h20);
        iss(0, 8'hB4, 8'h5A, 8'h5A, 3, 1, 8'h00, 6'h30);
        iss(0, 8'hD0, 8'h81, 8'h00, 2, 1, 8'hC0, 6'h28);
        iss(1, 8'hC0, 8'h81, 8'h00, 2, 1, 8'h40, 6'h24);
        iss(0, 8'h22, 8'h10, 8'h01, 3, 1, 8'h0F, 6'h03);
        iss(0, 8'h72, 8'hF0, 8'h0F, 3, 0, 8'h00, 6'h13);
        iss(0, 8'h62, 8'hF0, 8'h0F, 3, 0, 8'h00, 6'h03);
        iss(0, 8'hF0, 8'h12, 8'h00, 2, 1, 8'h21, 6'h03);
        iss(0, 8'hB7, 8'hFF, 8'h0F, 4, 1, 8'hF0, 6'h0B);
        iss(0, 8'h01, 8'h00, 8'h5A, 2, 0, 8'h00, 6'h0B);
        chk("pointer", working_group_pointer_o, 8'h5A);
        chk("user kept", flags_o[1:0], 2'b10);
        iss(0, 8'h6F, 8'h00, 8'h00, 2, 0, 8'h00, 6'h0B);
        iss(0, 8'h5F, 8'h00, 8'h00, 2, 0, 8'h00, 6'h0B);
    endtask : t_alu
    task automatic t_bad;
        @(negedge clk_i);
        {prefix_i, opcode_i, issue_valid_i} = {1'b1, 8'hD0, 1'b1};
        @(negedge clk_i);
        {prefix_i, issue_valid_i} = 2'b00;
        chk("illegal", {illegal_o, done_o, flags_o}, {2'b10, 8'h2E});
        @(negedge clk_i);
        chk("illegal end", illegal_o, 1'b0);
    endtask : t_bad
    task automatic t_exit;
        @(negedge clk_i);
        {irq_exit_i, stack_flags_i} = {1'b1, 8'hA6};
        @(negedge clk_i);
        irq_exit_i = 1'b0;
        chk("restore", flags_o, 8'hA6);
        for (int i = 4; i < 16; i++) begin
            if (i[2]) begin
                @(negedge clk_i);
                cond_i = i[3:0];
                #1;
                chk("cond", cond_true_o, stack_flags_i[i[2:0]] ^ i[3]);
            end
        end
    endtask : t_exit
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #5000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge clk_i);
        rst_b_i = 1'b1;
        chk("reset", {done_o, flags_o[7:2]}, 7'h00);
        t_user();
        t_alu();
        t_bad();
        trap(0, 8'h2E);
        trap(1, 8'h2E);
        t_exit();
        stop_test();
    end
endmodule : citf_core_test
